/* hw/stpwm_defines.vh */
// Register offsets, field positions, reset values and timing counts for the step/PWM output block
`ifndef STPWM_DEFINES_VH
`define STPWM_DEFINES_VH

// Group registers
`define STPWM_A_CTRL     8'h00
`define STPWM_A_PWM_EN   8'h01
`define STPWM_A_PWM_PER  8'h02
`define STPWM_A_STEP_EN  8'h03
`define STPWM_A_SETUP    8'h04
`define STPWM_A_WIDTH    8'h05
`define STPWM_A_GAP      8'h06
`define STPWM_A_DOUT     8'h07
`define STPWM_A_DINV     8'h08
`define STPWM_A_DIN      8'h09
// Per-channel register banks, four words each
`define STPWM_A_PWM_VAL  8'h10
`define STPWM_A_PWM_RCP  8'h14
`define STPWM_A_FLOOR    8'h18
`define STPWM_A_CEIL     8'h1C
`define STPWM_A_DUTY     8'h20
`define STPWM_A_VEL      8'h24
`define STPWM_A_VSCALE   8'h28
`define STPWM_A_VMAX     8'h2C
`define STPWM_A_FREQ     8'h30
`define STPWM_A_ENC_CNT  8'h34
`define STPWM_A_ENC_RCP  8'h38
`define STPWM_A_ENC_POS  8'h3C

// Field positions
`define STPWM_CTRL_COMMIT 0
`define STPWM_CTRL_SNAP   1
`define STPWM_PRE_LSB     4

// Clock and tick
`define STPWM_CLK_HZ   100000000
`define STPWM_CLK_NS   10
`define STPWM_TICK_NS  100
`define STPWM_TICK_DIV ((`STPWM_TICK_NS + `STPWM_CLK_NS - 1) / `STPWM_CLK_NS)
`define STPWM_TICK_HZ  (1000000000 / `STPWM_TICK_NS)

// Carrier limits
`define STPWM_FMIN_HZ  153
`define STPWM_FMAX_HZ  500000
`define STPWM_PER_MIN  ((`STPWM_CLK_HZ + `STPWM_FMAX_HZ - 1) / `STPWM_FMAX_HZ)
`define STPWM_PER_MAX  (`STPWM_CLK_HZ / `STPWM_FMIN_HZ)

// Duty format and burst
`define STPWM_DUTY_FULL 13'h1000
`define STPWM_DUTY_SH   12
`define STPWM_BOOT_N    3'h4

// Reset values
`define STPWM_RST_PER   20'h01388
`define STPWM_RST_SETUP 16'h000A
`define STPWM_RST_WIDTH 16'h000A
`define STPWM_RST_GAP   16'h000A
`define STPWM_RST_RCP   16'h1000
`define STPWM_RST_VMAX  16'h7FFF

`endif

/* hw/stpwm_stepgen.v */
// One step pulse generator channel with rate accumulator and setup/pulse/gap timing
`timescale 1ns/1ps
`default_nettype none
`include "stpwm_defines.vh"
module stpwm_stepgen (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire        tick_i,
  // Settings
  input  wire        en_i,
  input  wire        neg_i,
  input  wire [31:0] rate_i,
  input  wire [15:0] setup_i,
  input  wire [15:0] width_i,
  input  wire [15:0] gap_i,
  // Outputs
  output reg         step_o,
  output reg         dir_o,
  output reg  [31:0] freq_o
);
  localparam [1:0] S_IDLE  = 2'd0;
  localparam [1:0] S_SETUP = 2'd1;
  localparam [1:0] S_PULSE = 2'd2;
  localparam [1:0] S_GAP   = 2'd3;
  localparam [31:0] TICK_HZ = `STPWM_TICK_HZ;

  reg  [1:0]  st_q;
  reg  [15:0] cnt_q;
  reg  [31:0] acc_q;
  reg         pend_q;
  wire [32:0] acc_n = {1'b0, acc_q} + {1'b0, freq_o};
  wire        last  = (cnt_q <= 16'h0001);

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= S_IDLE;
      cnt_q  <= 16'h0000;
      acc_q  <= 32'h0000_0000;
      pend_q <= 1'b0;
      step_o <= 1'b0;
      dir_o  <= 1'b0;
      freq_o <= 32'h0000_0000;
    end else if (!en_i) begin
      st_q   <= S_IDLE;
      acc_q  <= 32'h0000_0000;
      pend_q <= 1'b0;
      step_o <= 1'b0;
      dir_o  <= 1'b0;
      freq_o <= 32'h0000_0000;
    end else if (tick_i) begin
      if (acc_n >= {1'b0, TICK_HZ}) begin
        acc_q  <= acc_n[31:0] - TICK_HZ;
        pend_q <= 1'b1;
      end else begin
        acc_q <= acc_n[31:0];
      end
      case (st_q)
        S_IDLE: begin
          freq_o <= (rate_i >= TICK_HZ) ? TICK_HZ - 32'h1 : rate_i;
          if (neg_i != dir_o) begin
            dir_o <= neg_i;
            cnt_q <= setup_i;
            st_q  <= S_SETUP;
          end else if (pend_q) begin
            pend_q <= (acc_n >= {1'b0, TICK_HZ}); // New wrap in this tick stays pending
            step_o <= 1'b1;
            cnt_q  <= width_i;
            st_q   <= S_PULSE;
          end
        end
        S_SETUP: begin
          cnt_q <= cnt_q - 16'h1;
          if (last) begin
            st_q <= S_IDLE;
          end
        end
        S_PULSE: begin
          cnt_q <= cnt_q - 16'h1;
          if (last) begin
            step_o <= 1'b0;
            cnt_q  <= gap_i;
            st_q   <= S_GAP;
          end
        end
        S_GAP: begin
          cnt_q <= cnt_q - 16'h1;
          if (last) begin
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* hw/stpwm_top.v */
// Step and PWM output channels with digital I/O and encoder readback behind a register port
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "stpwm_defines.vh"
module stpwm_top #(
  parameter NDIO = 8
) (
  // Clock and reset
  input  wire            mclk_i,
  input  wire            rst_n_i,
  // Register port
  input  wire [7:0]      addr_i,
  input  wire [31:0]     wdata_i,
  input  wire            wr_i,
  input  wire            rd_i,
  output reg  [31:0]     rdata_o,
  // Field inputs
  input  wire [NDIO-1:0] din_i,
  input  wire [63:0]     enc_count_i,
  // Field outputs
  output reg  [NDIO-1:0] dout_o,
  output wire [3:0]      pwm_up_o,
  output wire [3:0]      pwm_dn_o,
  output wire [3:0]      pwm_dir_o,
  output wire [3:0]      step_o,
  output wire [3:0]      step_dir_o
);
  localparam integer PER_MIN_I = `STPWM_PER_MIN;
  localparam integer PER_MAX_I = `STPWM_PER_MAX;
  localparam integer TDIV_I    = `STPWM_TICK_DIV;
  localparam [19:0]  PER_MIN   = PER_MIN_I[19:0];
  localparam [19:0]  PER_MAX   = PER_MAX_I[19:0];
  localparam [3:0]   TDIV      = TDIV_I[3:0];

  function [15:0] f_abs;
    input [15:0] v;
    begin
      f_abs = v[15] ? (~v + 16'h1) : v;
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] base;
    begin
      hit = (a[7:2] == base[7:2]);
    end
  endfunction

  integer i;
  // Host-written shadow set and committed live set; erc_q takes effect at once and esn_q and din_q hold snapshots
  reg [15:0] pv_s [0:3], pv_l [0:3];
  reg [15:0] rcp_s [0:3], rcp_l [0:3];
  reg [12:0] flo_s [0:3], flo_l [0:3];
  reg [12:0] cei_s [0:3], cei_l [0:3];
  reg [15:0] sv_s [0:3], sv_l [0:3];
  reg [15:0] ss_s [0:3], ss_l [0:3];
  reg [15:0] sm_s [0:3], sm_l [0:3];
  reg [15:0] erc_q [0:3];
  reg [15:0] esn_q [0:3];
  reg [3:0]  pen_s, pen_l, pre_s, pre_l, sen_s, sen_l;
  reg [19:0] per_s, per_l;
  reg [15:0] sup_s, sup_l, swd_s, swd_l, sgp_s, sgp_l;
  reg [NDIO-1:0] do_s, inv_s, din_q;
  reg [3:0]  tdiv_q;
  reg        tick_q;
  wire [51:0] duty_rb;
  wire [127:0] freq_rb;
  wire [1:0] ch = addr_i[1:0];
  wire [19:0] wper = (wdata_i[19:0] < PER_MIN) ? PER_MIN :
                     ((wdata_i[31:20] != 12'h0) || (wdata_i[19:0] > PER_MAX)) ? PER_MAX : wdata_i[19:0];
  wire commit = wr_i && (addr_i == `STPWM_A_CTRL) && wdata_i[`STPWM_CTRL_COMMIT];
  wire snap   = wr_i && (addr_i == `STPWM_A_CTRL) && wdata_i[`STPWM_CTRL_SNAP];

  // 100 ns tick divider
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdiv_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tdiv_q == TDIV - 4'h1);
      tdiv_q <= (tdiv_q == TDIV - 4'h1) ? 4'h0 : tdiv_q + 4'h1;
    end
  end

  // Register writes, commit and snapshot
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        pv_s[i]  <= 16'h0000;
        pv_l[i]  <= 16'h0000;
        rcp_s[i] <= `STPWM_RST_RCP;
        rcp_l[i] <= `STPWM_RST_RCP;
        flo_s[i] <= 13'h0000;
        flo_l[i] <= 13'h0000;
        cei_s[i] <= `STPWM_DUTY_FULL;
        cei_l[i] <= `STPWM_DUTY_FULL;
        sv_s[i]  <= 16'h0000;
        sv_l[i]  <= 16'h0000;
        ss_s[i]  <= 16'h0001;
        ss_l[i]  <= 16'h0001;
        sm_s[i]  <= `STPWM_RST_VMAX;
        sm_l[i]  <= `STPWM_RST_VMAX;
        erc_q[i] <= `STPWM_RST_RCP;
        esn_q[i] <= 16'h0000;
      end
      pen_s  <= 4'h0;
      pen_l  <= 4'h0;
      pre_s  <= 4'h0;
      pre_l  <= 4'h0;
      sen_s  <= 4'h0;
      sen_l  <= 4'h0;
      per_s  <= `STPWM_RST_PER;
      per_l  <= `STPWM_RST_PER;
      sup_s  <= `STPWM_RST_SETUP;
      sup_l  <= `STPWM_RST_SETUP;
      swd_s  <= `STPWM_RST_WIDTH;
      swd_l  <= `STPWM_RST_WIDTH;
      sgp_s  <= `STPWM_RST_GAP;
      sgp_l  <= `STPWM_RST_GAP;
      do_s   <= {NDIO{1'b0}};
      inv_s  <= {NDIO{1'b0}};
      din_q  <= {NDIO{1'b0}};
      dout_o <= {NDIO{1'b0}};
    end else begin
      if (wr_i) begin
        case (addr_i)
          `STPWM_A_PWM_EN: begin
            pen_s <= wdata_i[3:0];
            pre_s <= wdata_i[`STPWM_PRE_LSB +: 4];
          end
          `STPWM_A_PWM_PER: per_s <= wper;
          `STPWM_A_STEP_EN: sen_s <= wdata_i[3:0];
          `STPWM_A_SETUP:   sup_s <= wdata_i[15:0];
          `STPWM_A_WIDTH:   swd_s <= wdata_i[15:0];
          `STPWM_A_GAP:     sgp_s <= wdata_i[15:0];
          `STPWM_A_DOUT:    do_s  <= wdata_i[NDIO-1:0];
          `STPWM_A_DINV:    inv_s <= wdata_i[NDIO-1:0];
          default: ;
        endcase
        if (hit(addr_i, `STPWM_A_PWM_VAL)) pv_s[ch] <= wdata_i[15:0];
        if (hit(addr_i, `STPWM_A_PWM_RCP)) rcp_s[ch] <= wdata_i[15:0];
        if (hit(addr_i, `STPWM_A_FLOOR)) flo_s[ch] <= wdata_i[12] ? `STPWM_DUTY_FULL : wdata_i[12:0];
        if (hit(addr_i, `STPWM_A_CEIL)) cei_s[ch] <= wdata_i[12] ? `STPWM_DUTY_FULL : wdata_i[12:0];
        if (hit(addr_i, `STPWM_A_VEL)) sv_s[ch] <= wdata_i[15:0];
        if (hit(addr_i, `STPWM_A_VSCALE)) ss_s[ch] <= wdata_i[15:0];
        if (hit(addr_i, `STPWM_A_VMAX)) sm_s[ch] <= wdata_i[15:0];
        if (hit(addr_i, `STPWM_A_ENC_RCP)) erc_q[ch] <= wdata_i[15:0];
      end
      if (commit) begin
        for (i = 0; i < 4; i = i + 1) begin
          pv_l[i]  <= pv_s[i];
          rcp_l[i] <= rcp_s[i];
          flo_l[i] <= flo_s[i];
          cei_l[i] <= cei_s[i];
          sv_l[i]  <= sv_s[i];
          ss_l[i]  <= ss_s[i];
          sm_l[i]  <= sm_s[i];
        end
        pen_l  <= pen_s;
        pre_l  <= pre_s;
        sen_l  <= sen_s;
        per_l  <= per_s;
        sup_l  <= sup_s;
        swd_l  <= swd_s;
        sgp_l  <= sgp_s;
        dout_o <= do_s ^ inv_s;
      end else begin
        dout_o <= dout_o;
      end
      if (snap) begin
        din_q <= din_i;
        for (i = 0; i < 4; i = i + 1) begin
          esn_q[i] <= enc_count_i[16*i +: 16];
        end
      end
    end
  end

  // PWM and step channels
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gch
      wire [15:0] p_mag = f_abs(pv_l[g]);
      wire [31:0] p_raw = p_mag * rcp_l[g];
      wire [12:0] p_sat = (p_raw[31:12] > {7'h0, `STPWM_DUTY_FULL}) ? `STPWM_DUTY_FULL : p_raw[24:12];
      wire [12:0] p_lo  = (p_sat < flo_l[g]) ? flo_l[g] : p_sat;
      wire [12:0] p_dc  = (p_lo > cei_l[g]) ? cei_l[g] : p_lo;
      wire [32:0] p_prd = p_dc * per_l;
      reg  [19:0] cnt_q, per_q, thr_q;
      reg  [12:0] dq;
      reg  [2:0]  boot_q;
      reg         en_q, neg_q, up_q, dn_q, dir_q;
      wire        start = pen_l[g] & ~en_q;
      wire        wrap  = (cnt_q >= per_q - 20'h1);
      wire [2:0]  b_nx  = start ? (pre_l[g] ? `STPWM_BOOT_N : 3'h0) : ((boot_q != 3'h0) ? boot_q - 3'h1 : 3'h0);
      wire        on    = en_q && (cnt_q < thr_q);
      wire [15:0] s_mag = f_abs(sv_l[g]);
      wire [15:0] s_clp = (s_mag > sm_l[g]) ? sm_l[g] : s_mag;
      wire [31:0] s_rate = s_clp * ss_l[g];

      always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cnt_q  <= 20'h0;
          per_q  <= `STPWM_RST_PER;
          thr_q  <= 20'h0;
          dq     <= 13'h0;
          boot_q <= 3'h0;
          en_q   <= 1'b0;
          neg_q  <= 1'b0;
          up_q   <= 1'b0;
          dn_q   <= 1'b0;
          dir_q  <= 1'b0;
        end else begin
          en_q <= pen_l[g];
          if (!pen_l[g]) begin
            cnt_q  <= 20'h0;
            thr_q  <= 20'h0;
            boot_q <= 3'h0;
          end else if (start || wrap) begin
            cnt_q  <= 20'h0;
            per_q  <= per_l;
            neg_q  <= pv_l[g][15];
            dq     <= p_dc;
            boot_q <= b_nx;
            thr_q  <= (b_nx != 3'h0) ? {3'h0, per_l[19:3]} : p_prd[31:12];
          end else begin
            cnt_q <= cnt_q + 20'h1;
          end
          up_q  <= on && pen_l[g] && ((boot_q != 3'h0) ? boot_q[0] : ~neg_q);
          dn_q  <= on && pen_l[g] && ((boot_q != 3'h0) ? ~boot_q[0] : neg_q);
          dir_q <= en_q && pen_l[g] && neg_q;
        end
      end

      assign pwm_up_o[g]  = up_q;
      assign pwm_dn_o[g]  = dn_q;
      assign pwm_dir_o[g] = dir_q;
      assign duty_rb[13*g +: 13] = dq;

      stpwm_stepgen u_step (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .tick_i  (tick_q),
        .en_i    (sen_l[g]),
        .neg_i   (sv_l[g][15]),
        .rate_i  (s_rate),
        .setup_i (sup_l),
        .width_i (swd_l),
        .gap_i   (sgp_l),
        .step_o  (step_o[g]),
        .dir_o   (step_dir_o[g]),
        .freq_o  (freq_rb[32*g +: 32])
      );
    end
  endgenerate

  // Read mux
  reg [31:0] rd_d;
  wire [31:0] epos = $signed(esn_q[ch]) * $signed({1'b0, erc_q[ch]});
  always @* begin
    rd_d = 32'h0000_0000;
    case (addr_i)
      `STPWM_A_PWM_EN:  rd_d = {24'h0, pre_s, pen_s};
      `STPWM_A_PWM_PER: rd_d = {12'h0, per_s};
      `STPWM_A_STEP_EN: rd_d = {28'h0, sen_s};
      `STPWM_A_SETUP:   rd_d = {16'h0, sup_s};
      `STPWM_A_WIDTH:   rd_d = {16'h0, swd_s};
      `STPWM_A_GAP:     rd_d = {16'h0, sgp_s};
      `STPWM_A_DOUT:    rd_d[NDIO-1:0] = do_s;
      `STPWM_A_DINV:    rd_d[NDIO-1:0] = inv_s;
      `STPWM_A_DIN:     rd_d[2*NDIO-1:0] = {~din_q, din_q};
      default: begin
        if (hit(addr_i, `STPWM_A_PWM_VAL)) rd_d = {16'h0, pv_s[ch]};
        if (hit(addr_i, `STPWM_A_PWM_RCP)) rd_d = {16'h0, rcp_s[ch]};
        if (hit(addr_i, `STPWM_A_FLOOR))   rd_d = {19'h0, flo_s[ch]};
        if (hit(addr_i, `STPWM_A_CEIL))    rd_d = {19'h0, cei_s[ch]};
        if (hit(addr_i, `STPWM_A_DUTY))    rd_d = {19'h0, duty_rb[13*ch +: 13]};
        if (hit(addr_i, `STPWM_A_VEL))     rd_d = {16'h0, sv_s[ch]};
        if (hit(addr_i, `STPWM_A_VSCALE))  rd_d = {16'h0, ss_s[ch]};
        if (hit(addr_i, `STPWM_A_VMAX))    rd_d = {16'h0, sm_s[ch]};
        if (hit(addr_i, `STPWM_A_FREQ))    rd_d = freq_rb[32*ch +: 32];
        if (hit(addr_i, `STPWM_A_ENC_CNT)) rd_d = {{16{esn_q[ch][15]}}, esn_q[ch]};
        if (hit(addr_i, `STPWM_A_ENC_RCP)) rd_d = {16'h0, erc_q[ch]};
        if (hit(addr_i, `STPWM_A_ENC_POS)) rd_d = epos;
      end
    endcase
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? rd_d : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* sim/stpwm_host.sv */
// Host register master model for the step/PWM block
`timescale 1ns/1ps
`default_nettype none
module stpwm_host (
  // Clock
  input  wire logic        mclk_i,
  // Register port
  output var logic [7:0]   addr_o,
  output var logic [31:0]  wdata_o,
  output var logic         wr_o,
  output var logic         rd_o,
  input  wire logic [31:0] rdata_i
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One write cycle, lines scrambled once released
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // One read cycle, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* sim/stpwm_top_sva.sv */
// Assertion checker for the step/PWM output block
`timescale 1ns/1ps
`default_nettype none
module stpwm_sva #(
  parameter NDIO = 8
) (
  // Clock and reset
  input wire logic            mclk_i,
  input wire logic            rst_n_i,
  // Register port
  input wire logic [7:0]      addr_i,
  input wire logic [31:0]     wdata_i,
  input wire logic            wr_i,
  input wire logic            rd_i,
  input wire logic [31:0]     rdata_o,
  // Field pins
  input wire logic [NDIO-1:0] din_i,
  input wire logic [63:0]     enc_count_i,
  input wire logic [NDIO-1:0] dout_o,
  input wire logic [3:0]      pwm_up_o,
  input wire logic [3:0]      pwm_dn_o,
  input wire logic [3:0]      pwm_dir_o,
  input wire logic [3:0]      step_o,
  input wire logic [3:0]      step_dir_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  rdata_slot_a: assert property (rdata_o != 32'h0 |-> $past(rd_i))
    else $error("read data outside its slot");
  ctrl_read_a: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 32'h0)
    else $error("control word not read as zero");
  din_pair_a: assert property (rd_i && addr_i == 8'h09 |=> rdata_o[15:8] == ~rdata_o[7:0])
    else $error("input copy not complemented");
  duty_limit_a: assert property (rd_i && addr_i[7:2] == 6'h08 |=> rdata_o <= 32'h1000)
    else $error("duty above full scale");
  step_width_a: assert property ($rose(step_o[0]) |-> step_o[0] [*8])
    else $error("step pulse too short");
  step_gap_a: assert property ($fell(step_o[0]) |-> !step_o[0] [*8])
    else $error("step gap too short");
  dir_setup_a: assert property ($changed(step_dir_o[0]) |-> !step_o[0] [*8])
    else $error("step too soon after direction change");
  dir_hold_a: assert property (step_o[0] |-> $stable(step_dir_o[0]))
    else $error("direction moved during step");
  pwm_side_a: assert property ((pwm_up_o & pwm_dn_o) == 4'h0)
    else $error("both drive sides active");
  dout_commit_a: assert property ($changed(dout_o) |-> $past(wr_i) && $past(addr_i) == 8'h00 && $past(wdata_i[0]))
    else $error("outputs moved without commit");
  step_c: cover property ($rose(step_o[0]));
  pwm_dn_c: cover property ($rose(pwm_dn_o[0]));
  dout_c: cover property ($changed(dout_o));
endmodule
bind stpwm_top stpwm_sva #(.NDIO(NDIO)) u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .din_i(din_i), .enc_count_i(enc_count_i),
  .dout_o(dout_o), .pwm_up_o(pwm_up_o), .pwm_dn_o(pwm_dn_o), .pwm_dir_o(pwm_dir_o), .step_o(step_o),
  .step_dir_o(step_dir_o));
`default_nettype wire

/* sim/tb_step_pwm_output_channels.sv */
// Self-checking testbench for the step/PWM output block
`timescale 1ns/1ps
`default_nettype none
`include "stpwm_defines.vh"
module tb_step_pwm_output_channels;
  logic        mclk_i, rst_n_i, wr, rd;
  logic [7:0]  addr, din, dout, dsnap;
  logic [31:0] wdata, rdata;
  logic [63:0] enc, esnap;
  logic [3:0]  up, dn, pdir, stp, sdir;
  int          err_count, cmp_count, cyc;
  stpwm_top #(.NDIO(8)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .din_i(din), .enc_count_i(enc), .dout_o(dout), .pwm_up_o(up), .pwm_dn_o(dn),
    .pwm_dir_o(pdir), .step_o(stp), .step_dir_o(sdir));
  stpwm_host host (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host.rd_reg(a, v);
    check(v, exp);
  endtask
  task automatic commit;
    host.wr_reg(`STPWM_A_CTRL, 32'h1);
  endtask
  task automatic lvl_wait(input logic lvl, output int n);
    n = 0;
    while (stp[0] !== lvl && n < 5000) begin
      @(negedge mclk_i);
      n++;
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [31:0] duty_exp(input logic [15:0] c, input logic [31:0] fl, input logic [31:0] cl);
    logic [31:0] m;
    m = {16'h0, c[15] ? 16'h0 - c : c};
    if (m > 32'h1000) m = 32'h1000;
    if (m < fl) m = fl;
    if (m > cl) m = cl;
    return m;
  endfunction
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    logic [15:0] d, c;
    logic [31:0] du;
    logic [7:0]  prev;
    int          w, g, hi, lo;
    logic [15:0] cmds [3] = '{16'h0800, 16'hF000, 16'h0000};
    logic [31:0] fls [3] = '{32'h0, 32'h0, 32'h0400};
    logic [31:0] cls [3] = '{32'h1000, 32'h1000, 32'h0C00};
    rst_n_i = 1'b0;
    din = 8'h00;
    enc = 64'h0;
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    prev = 8'h00;
    void'($urandom(66));
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rdchk(`STPWM_A_PWM_PER, 32'h1388);
    rdchk(`STPWM_A_WIDTH, 32'h000A);
    rdchk(`STPWM_A_VMAX, 32'h7FFF);
    host.wr_reg(8'hA0, 32'hFFFFFFFF);
    rdchk(8'hA0, 32'h0);
    rdchk(`STPWM_A_CTRL, 32'h0);
    host.wr_reg(`STPWM_A_PWM_PER, 32'h1);
    rdchk(`STPWM_A_PWM_PER, 32'd200);
    host.wr_reg(`STPWM_A_PWM_PER, 32'hFFFFF);
    rdchk(`STPWM_A_PWM_PER, 32'd653594);
    // Outputs with inversion, held until commit
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 16'hFFFF : 16'($urandom);
      host.wr_reg(`STPWM_A_DOUT, {24'h0, d[7:0]});
      host.wr_reg(`STPWM_A_DINV, {24'h0, d[15:8]});
      check({24'h0, dout}, {24'h0, prev});
      commit();
      @(negedge mclk_i);
      prev = d[7:0] ^ d[15:8];
      check({24'h0, dout}, {24'h0, prev});
    end
    // Snapshot of inputs and counts, then inputs move
    @(posedge mclk_i);
    din <= 8'($urandom);
    enc <= {$urandom, 16'($urandom), 16'h8000};
    host.wr_reg(`STPWM_A_ENC_RCP, 32'h0000C000);
    dsnap = din;
    esnap = enc;
    host.wr_reg(`STPWM_A_CTRL, 32'h3);
    din <= ~din;
    enc <= ~enc;
    rdchk(`STPWM_A_DIN, {16'h0, ~dsnap, dsnap});
    for (int k = 0; k < 4; k++)
      rdchk(8'(`STPWM_A_ENC_CNT + k), {{16{esnap[16*k+15]}}, esnap[16*k+:16]});
    rdchk(`STPWM_A_ENC_POS, 32'(32'shFFFF8000 * 32'sh0000C000));
    // Duty scaling, limits and side selection on channel 0
    host.wr_reg(`STPWM_A_PWM_PER, 32'd200);
    for (int k = 0; k < 3; k++) begin
      c = (k == 2) ? 16'($urandom) : cmds[k];
      host.wr_reg(`STPWM_A_PWM_VAL, {16'h0, c});
      host.wr_reg(`STPWM_A_FLOOR, fls[k]);
      host.wr_reg(`STPWM_A_CEIL, cls[k]);
      host.wr_reg(`STPWM_A_PWM_EN, 32'h1);
      commit();
      repeat (450) @(posedge mclk_i);
      du = duty_exp(c, fls[k], cls[k]);
      rdchk(`STPWM_A_DUTY, du);
      hi = 0;
      lo = 0;
      repeat (200) begin
        @(negedge mclk_i);
        hi += c[15] ? dn[0] : up[0];
        lo += c[15] ? up[0] : dn[0];
      end
      check(32'(hi), (du * 32'd200) >> 12);
      check(32'(lo), 32'h0);
      check({31'h0, pdir[0]}, {31'h0, c[15]});
    end
    // Precharge burst on a fresh enable: two periods each side at period/8
    host.wr_reg(`STPWM_A_PWM_EN, 32'h0);
    commit();
    repeat (4) @(posedge mclk_i);
    host.wr_reg(`STPWM_A_PWM_EN, 32'h11);
    commit();
    hi = 0;
    lo = 0;
    repeat (800) begin
      @(negedge mclk_i);
      hi += up[0];
      lo += dn[0];
    end
    check(32'(hi), 32'd50);
    check(32'(lo), 32'd50);
    host.wr_reg(`STPWM_A_PWM_EN, 32'h0);
    commit();
    repeat (250) @(negedge mclk_i);
    check({20'h0, up, dn, pdir}, 32'h0);
    // Step rate, clamp, direction and timing on channel 0
    host.wr_reg(`STPWM_A_SETUP, 32'd4);
    host.wr_reg(`STPWM_A_WIDTH, 32'd3);
    host.wr_reg(`STPWM_A_GAP, 32'd5);
    host.wr_reg(`STPWM_A_VSCALE, 32'd1000);
    host.wr_reg(`STPWM_A_VMAX, 32'd200);
    host.wr_reg(`STPWM_A_STEP_EN, 32'h1);
    for (int s = 0; s < 3; s++) begin
      host.wr_reg(`STPWM_A_VEL, s == 0 ? 32'd300 : s == 1 ? 32'h0000FED4 : 32'h7FFF);
      if (s == 2)
        host.wr_reg(`STPWM_A_VMAX, 32'h7FFF);
      commit();
      lvl_wait(1'b1, w);
      lvl_wait(1'b0, w);
      lvl_wait(1'b1, w);
      lvl_wait(1'b0, w);
      check(32'(w), 32'd30);
      lvl_wait(1'b1, g);
      if (s < 2) begin
        check(32'(w + g >= 490 && w + g <= 510), 32'h1);
        rdchk(`STPWM_A_FREQ, 32'd200000);
        check({31'h0, sdir[0]}, 32'(s));
      end else begin
        check(32'(w + g >= 80 && w + g <= 100), 32'h1);
        rdchk(`STPWM_A_FREQ, 32'd9999999);
      end
    end
    // Disable only between pulses so no pulse is cut short
    lvl_wait(1'b0, w);
    host.wr_reg(`STPWM_A_STEP_EN, 32'h0);
    commit();
    repeat (300) @(negedge mclk_i);
    check({24'h0, stp, sdir}, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
